// ==== hdl/ddbl_loader.sv ====
// Dual converter bus loader: processor bus decoding, sample buffers and channel latches.
// Notes on behaviour
// - Two 12-bit latches, one per channel.
// - 8-bit and 4-bit buffers assemble each sample.
// - 12-bit or 8-bit resolution, high byte kept.
// - Each channel updates without touching the other.
// - Command lines decoded only during I/O.
// - Writes accepted only with direction line low.
// - Buffers capture data at data pulse fall.
// - Address pulse copies buffers into channel latch.
// - Clear sets every buffer bit high immediately.
// - First address pulse after clear loads both.
// - Codes 1..7 output, 9..F input commands.
// - Code and group come from links; mode from the control register.
// - Group select latched; respond only on match.
// - Group low nibble one-hot, high nibble binary.
// - Cmd 62 loads bits 7..4, 63 full byte.
// - Cmd 64 transfers; bit0 ch2, bit1 ch1.
//
// Design decisions made here: the register addresses and the AXI4-Lite slave port.
`default_nettype none
module ddbl_loader (
  input  wire logic        ref_clk,
  input  wire logic        nrst,
  input  wire logic [7:0]  processor_data_bus,
  input  wire logic        command_line_0,
  input  wire logic        command_line_1,
  input  wire logic        command_line_2,
  input  wire logic        transfer_direction_line,
  input  wire logic        address_timing_pulse,
  input  wire logic        data_timing_pulse,
  input  wire logic        system_clear_n,
  input  wire logic [7:0]  group_select_links,
  input  wire logic [1:0]  input_code_links,
  output logic [11:0]      ch1_converter_code,
  output logic [11:0]      ch2_converter_code,
  output logic             ch1_convert_start,
  output logic             ch2_convert_start,
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  // Decides whether a latched group byte addresses this board.
  function automatic logic group_hit(input logic [7:0] grp, input logic [7:0] links);
    logic low_ok;
    low_ok = (links[3:0] == 4'h0) ? (grp[3:0] == 4'h0) : ((grp[3:0] & links[3:0]) != 4'h0);
    return low_ok && (grp[7:4] == links[7:4]);
  endfunction : group_hit

  // Bundle of all pin inputs so that one synchroniser pair serves them all.
  localparam int PIN_W = 25;
  logic [PIN_W-1:0] pins_raw;       // Asynchronous pin inputs gathered together.
  logic [PIN_W-1:0] pins_meta_q;    // First synchroniser stage, read only by the second.
  logic [PIN_W-1:0] pins_sync_q;    // Second synchroniser stage, safe to use.
  logic             tpa_prev_q;     // Address pulse one cycle ago.
  logic             tpb_prev_q;     // Data pulse one cycle ago.
  logic             clear_prev_q;   // Clear line one cycle ago, for the first pulse after clear.

  assign pins_raw = {input_code_links, group_select_links, system_clear_n,
                     data_timing_pulse, address_timing_pulse, transfer_direction_line,
                     command_line_2, command_line_1, command_line_0, processor_data_bus};

  // Synchronised views of the pins.
  logic [7:0] bus_s;       // Data bus.
  logic [2:0] cmd_s;       // Command lines.
  logic       dir_s;       // Direction line, low for memory to peripheral.
  logic       tpa_s;       // Address timing pulse.
  logic       tpb_s;       // Data timing pulse.
  logic       clear_n_s;   // System clear, active low.
  logic [7:0] links_s;     // Group select links.
  logic [1:0] code_s;      // Input code links.

  assign bus_s     = pins_sync_q[7:0];
  assign cmd_s     = pins_sync_q[10:8];
  assign dir_s     = pins_sync_q[11];
  assign tpa_s     = pins_sync_q[12];
  assign tpb_s     = pins_sync_q[13];
  assign clear_n_s = pins_sync_q[14];
  assign links_s   = pins_sync_q[22:15];
  assign code_s    = pins_sync_q[24:23];

  // Two-stage synchroniser for every pin.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pins_meta_q <= '0;
      pins_sync_q <= '0;
    end else begin
      pins_meta_q <= pins_raw;
      pins_sync_q <= pins_meta_q;
    end
  end

  // Edge history of the timing pulses and clear.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      tpa_prev_q   <= 1'b0;
      tpb_prev_q   <= 1'b0;
      clear_prev_q <= 1'b0;
    end else begin
      tpa_prev_q   <= tpa_s;
      tpb_prev_q   <= tpb_s;
      clear_prev_q <= clear_n_s;
    end
  end

  // Bus command decode.
  logic tpb_fall;     // Trailing edge of the data pulse.
  logic tpa_rise;     // Leading edge of the address pulse.
  logic io_cycle;     // A nonzero command code marks an I/O instruction.
  logic out_write;    // Output command with data flowing to the board.
  logic selected;     // Latched group addresses this board.

  assign tpb_fall  = tpb_prev_q && !tpb_s;
  assign tpa_rise  = tpa_s && !tpa_prev_q;
  assign io_cycle  = (cmd_s != 3'h0);
  // Output commands have the direction line low; input commands are simply ignored.
  assign out_write = io_cycle && !dir_s && tpb_fall;

  logic [7:0]  group_q;     // Latched group select byte.
  logic [7:0]  buf_high_q;  // High-order buffer, holds the bus byte inverted.
  logic [3:0]  buf_low_q;   // Low-order buffer, holds bus bits 7..4 inverted.
  logic [11:0] ch1_latch_q; // Channel 1 sample latch.
  logic [11:0] ch2_latch_q; // Channel 2 sample latch.
  logic        pend_ch1_q;  // Channel 1 waits for the next address pulse.
  logic        pend_ch2_q;  // Channel 2 waits for the next address pulse.
  logic [31:0] control_q;   // Software control register.
  logic [11:0] sample;      // Sample assembled from the buffers.

  assign selected = group_hit(group_q, links_s);

  // Group select latch, every board takes it regardless of its own match.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      group_q <= ddbl_pkg::GROUP_RESET;
    end else if (out_write && cmd_s == ddbl_pkg::CMD_GROUP_SEL) begin
      group_q <= bus_s;
    end
  end

  // Buffers; clear forces them high at once, overriding any capture.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      buf_high_q <= ddbl_pkg::BUF_HIGH_RESET;
      buf_low_q  <= ddbl_pkg::BUF_LOW_RESET;
    end else if (!clear_n_s) begin
      buf_high_q <= ddbl_pkg::BUF_HIGH_RESET;
      buf_low_q  <= ddbl_pkg::BUF_LOW_RESET;
    end else if (out_write && selected) begin
      if (cmd_s == ddbl_pkg::CMD_LOAD_LOW) begin
        buf_low_q <= ~bus_s[7:4];
      end else if (cmd_s == ddbl_pkg::CMD_LOAD_HIGH) begin
        buf_high_q <= ~bus_s;
      end
    end
  end

  // Channel requests from the transfer command, or both after a clear.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pend_ch1_q <= 1'b1;
      pend_ch2_q <= 1'b1;
    end else if (!clear_n_s || (clear_n_s && !clear_prev_q)) begin
      pend_ch1_q <= 1'b1;
      pend_ch2_q <= 1'b1;
    end else if (out_write && selected && cmd_s == ddbl_pkg::CMD_TRANSFER) begin
      pend_ch1_q <= bus_s[ddbl_pkg::SEL_CH1_BIT];
      pend_ch2_q <= bus_s[ddbl_pkg::SEL_CH2_BIT];
    end else if (tpa_rise) begin
      pend_ch1_q <= 1'b0;
      pend_ch2_q <= 1'b0;
    end
  end

  // In eight-bit mode the low nibble is held at its idle value.
  assign sample = {buf_high_q,
                   control_q[ddbl_pkg::CTRL_EIGHT_BIT] ? ddbl_pkg::BUF_LOW_RESET : buf_low_q};

  // Channel latches load on the address pulse, each on its own request.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ch1_latch_q       <= {ddbl_pkg::BUF_HIGH_RESET, ddbl_pkg::BUF_LOW_RESET};
      ch2_latch_q       <= {ddbl_pkg::BUF_HIGH_RESET, ddbl_pkg::BUF_LOW_RESET};
      ch1_convert_start <= 1'b0;
      ch2_convert_start <= 1'b0;
    end else begin
      ch1_convert_start <= 1'b0;
      ch2_convert_start <= 1'b0;
      if (tpa_rise && clear_n_s && pend_ch1_q) begin
        ch1_latch_q       <= sample;
        ch1_convert_start <= 1'b1;
      end
      if (tpa_rise && clear_n_s && pend_ch2_q) begin
        ch2_latch_q       <= sample;
        ch2_convert_start <= 1'b1;
      end
    end
  end

  // Sign flip applied when the links select two's complement input.
  logic [11:0] code_flip;

  assign code_flip = (code_s == ddbl_pkg::CODE_TWOS) ? 12'h800 : 12'h000;

  // Converter codes follow a latch only when it loads, so a link settling cannot move them alone.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ch1_converter_code <= '0;
      ch2_converter_code <= '0;
    end else begin
      if (ch1_convert_start) begin
        ch1_converter_code <= ch1_latch_q ^ code_flip;
      end
      if (ch2_convert_start) begin
        ch2_converter_code <= ch2_latch_q ^ code_flip;
      end
    end
  end

  // Software bus: write address and data are held until both have arrived.
  logic        aw_have_q;   // Write address captured.
  logic        w_have_q;    // Write data captured.
  logic [3:0]  aw_addr_q;   // Captured write address.
  logic [31:0] w_data_q;    // Captured write data.
  logic [3:0]  w_strb_q;    // Captured byte strobes.
  logic        do_write;    // Both halves present and no response outstanding.

  assign s_axi_awready = !aw_have_q;
  assign s_axi_wready  = !w_have_q;
  assign do_write      = aw_have_q && w_have_q && !s_axi_bvalid;

  // Capture of the write address and data channels.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      aw_addr_q <= 4'h0;
      w_data_q  <= 32'h00000000;
      w_strb_q  <= 4'h0;
    end else begin
      if (s_axi_awvalid && !aw_have_q) begin
        aw_have_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end else if (do_write) begin
        aw_have_q <= 1'b0;
      end
      if (s_axi_wvalid && !w_have_q) begin
        w_have_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end else if (do_write) begin
        w_have_q <= 1'b0;
      end
    end
  end

  // Register write and write response; only the control register is writable.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      control_q    <= ddbl_pkg::CONTROL_RESET;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= ddbl_pkg::RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      if (aw_addr_q == ddbl_pkg::REG_CONTROL) begin
        if (w_strb_q[0]) begin
          control_q[ddbl_pkg::CTRL_EIGHT_BIT] <= w_data_q[ddbl_pkg::CTRL_EIGHT_BIT];
        end
        s_axi_bresp <= ddbl_pkg::RESP_OKAY;
      end else begin
        s_axi_bresp <= ddbl_pkg::RESP_SLVERR;
      end
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Read channel: one address at a time, answered the cycle after it is taken.
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= ddbl_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= ddbl_pkg::RESP_OKAY;
      if (s_axi_araddr == ddbl_pkg::REG_CONTROL) begin
        s_axi_rdata <= control_q;
      end else if (s_axi_araddr == ddbl_pkg::REG_STATUS) begin
        s_axi_rdata <= {23'h000000, selected, group_q};
      end else if (s_axi_araddr == ddbl_pkg::REG_CH1_LATCH) begin
        s_axi_rdata <= {20'h00000, ch1_latch_q};
      end else if (s_axi_araddr == ddbl_pkg::REG_CH2_LATCH) begin
        s_axi_rdata <= {20'h00000, ch2_latch_q};
      end else begin
        s_axi_rdata <= 32'h00000000;
        s_axi_rresp <= ddbl_pkg::RESP_SLVERR;
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule : ddbl_loader
`default_nettype wire

// ==== inc/ddbl_pkg.sv ====
// Constants shared by the dual converter bus loader: commands, links and register map.
`default_nettype none
package ddbl_pkg;
  // Width of the processor data bus in bits.
  localparam int DATA_W = 8;
  // Width of one channel sample in bits.
  localparam int SAMPLE_W = 12;
  // Width of the low-order buffer in bits.
  localparam int LOW_W = 4;
  // Command line codes (three low bits of the operand).
  localparam logic [2:0] CMD_GROUP_SEL = 3'h1;
  localparam logic [2:0] CMD_LOAD_LOW = 3'h2;
  localparam logic [2:0] CMD_LOAD_HIGH = 3'h3;
  localparam logic [2:0] CMD_TRANSFER = 3'h4;
  // Bus bit positions inside the transfer command byte.
  localparam int SEL_CH2_BIT = 0;
  localparam int SEL_CH1_BIT = 1;
  // Input code selections carried by the code links.
  localparam logic [1:0] CODE_STRAIGHT = 2'h0;
  localparam logic [1:0] CODE_OFFSET = 2'h1;
  localparam logic [1:0] CODE_TWOS = 2'h2;
  // Value that every buffer bit takes at clear.
  localparam logic [7:0] BUF_HIGH_RESET = 8'hff;
  localparam logic [3:0] BUF_LOW_RESET = 4'hf;
  // Latched group value after reset.
  localparam logic [7:0] GROUP_RESET = 8'h00;
  // Register byte addresses on the software bus.
  localparam logic [3:0] REG_CONTROL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_CH1_LATCH = 4'h8;
  localparam logic [3:0] REG_CH2_LATCH = 4'hc;
  // Control register field: eight-bit resolution mode.
  localparam int CTRL_EIGHT_BIT = 0;
  localparam logic [31:0] CONTROL_RESET = 32'h00000000;
  // Status register fields.
  localparam int STAT_GROUP_LSB = 0;
  localparam int STAT_MATCH_BIT = 8;
  // Bus response codes.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : ddbl_pkg
`default_nettype wire

// ==== tb/ddbl_cpu_model.sv ====
// Processor bus model: machine cycles with timing pulses, commands and clear.
`default_nettype none
module ddbl_cpu_model (
  input  wire logic  ref_clk,
  output logic [7:0] processor_data_bus,
  output logic       command_line_0,
  output logic       command_line_1,
  output logic       command_line_2,
  output logic       transfer_direction_line,
  output logic       address_timing_pulse,
  output logic       data_timing_pulse,
  output logic       system_clear_n
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle bus at time zero: no I/O command, pulses low, clear released.
  initial begin
    {transfer_direction_line, command_line_2, command_line_1, command_line_0} = 4'h0;
    {address_timing_pulse, data_timing_pulse, system_clear_n} = 3'h1;
    processor_data_bus = 8'h00;
  end
  // Waits a number of clock edges.
  task automatic hold(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : hold
  // One machine cycle; code bit 3 is the direction, bits 2..0 the command lines.
  task automatic mcycle(input logic [3:0] code, input logic [7:0] data);
    {transfer_direction_line, command_line_2, command_line_1, command_line_0} <= code;
    processor_data_bus <= data;
    hold(4);
    address_timing_pulse <= 1'b1;
    hold(4);
    address_timing_pulse <= 1'b0;
    hold(4);
    data_timing_pulse <= 1'b1;
    hold(4);
    data_timing_pulse <= 1'b0;
    hold(4);
    // Command lines drop after the instruction; the bus no longer holds the byte.
    {command_line_2, command_line_1, command_line_0} <= 3'h0;
    processor_data_bus <= ~data;
    hold(2);
  endtask : mcycle
  // System clear held low for a few clocks.
  task automatic clear();
    system_clear_n <= 1'b0;
    hold(4);
    system_clear_n <= 1'b1;
    hold(4);
  endtask : clear
endmodule : ddbl_cpu_model
`default_nettype wire

// ==== tb/ddbl_loader_tb_top.sv ====
// Bench for the loader: samples over the processor bus, clear and register access.
`default_nettype none
module ddbl_loader_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk, nrst, command_line_0, command_line_1, command_line_2;
  logic        transfer_direction_line, address_timing_pulse, data_timing_pulse;
  logic        system_clear_n, ch1_convert_start, ch2_convert_start;
  logic [7:0]  processor_data_bus;
  logic [11:0] ch1_converter_code, ch2_converter_code;
  logic [3:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int          num_errors = 0;
  int          tests_run = 0;
  int          starts1 = 0;             // Channel 1 start pulses seen.
  int          starts2 = 0;             // Channel 2 start pulses seen.
  logic [1:0]  input_code_links = 2'h0; // Input code links, straight binary at first.
  // One row: high byte, low byte, select byte and both expected codes.
  typedef struct packed {logic [7:0] hi, lo, sel; logic [11:0] e1, e2;} ddbl_row_type;
  ddbl_row_type rows [4] = '{'{8'h12, 8'h30, 8'h02, 12'hedc, 12'hfff},
                             '{8'h00, 8'hf0, 8'h01, 12'hedc, 12'hff0},
                             '{8'ha5, 8'h5a, 8'h03, 12'h5aa, 12'h5aa},
                             '{8'hff, 8'hff, 8'hfc, 12'h5aa, 12'h5aa}};
  // Links select group 30, straight code at first; strobes always full word.
  ddbl_loader dut (.*, .s_axi_wstrb(4'hf), .group_select_links(8'h30));
  ddbl_cpu_model cpu (.*);
  // 25 MHz clock.
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  // Counts the start pulses of each channel, so a stray load is caught.
  always @(posedge ref_clk) begin
    if (ch1_convert_start === 1'b1) starts1 <= starts1 + 1;
    if (ch2_convert_start === 1'b1) starts2 <= starts2 + 1;
  end
  // Counts and reports one comparison.
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask : chk
  // Prints the verdict and ends the run.
  task automatic print_verdict();
    if (num_errors == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : print_verdict
  // Register write; address and data released each as it is taken.
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do begin
      @(posedge ref_clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk("bresp", r, s_axi_bresp);
    // Lets an edge pass so a following call never reassigns bready in this step.
    @(posedge ref_clk);
  endtask : axi_wr
  // Register read with expected data and response.
  task automatic axi_rd(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do begin
      @(posedge ref_clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    chk("rresp", r, s_axi_rresp);
    chk("rdata", d, s_axi_rdata);
    // Lets an edge pass so a following call never reassigns rready in this step.
    @(posedge ref_clk);
  endtask : axi_rd
  // Group select, high byte, low byte, transfer, then a plain cycle for the load.
  task automatic load(input logic [7:0] g, hi, lo, sel);
    cpu.mcycle(4'h1, g);
    cpu.mcycle(4'h3, hi);
    cpu.mcycle(4'h2, lo);
    cpu.mcycle(4'h4, sel);
    cpu.mcycle(4'h0, 8'h00);
  endtask : load
  // Compares both converter codes.
  task automatic codes(input logic [11:0] e1, e2);
    chk("ch1_converter_code", e1, ch1_converter_code);
    chk("ch2_converter_code", e2, ch2_converter_code);
  endtask : codes
  // Main sequence.
  initial begin
    nrst = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 40'h0;
    repeat (5) @(posedge ref_clk);
    nrst <= 1'b1;
    @(posedge ref_clk);
    axi_rd(4'h0, 32'h0, ddbl_pkg::RESP_OKAY);
    cpu.mcycle(4'h0, 8'h00);
    codes(12'hfff, 12'hfff);
    foreach (rows[i]) begin
      load(8'h30, rows[i].hi, rows[i].lo, rows[i].sel);
      codes(rows[i].e1, rows[i].e2);
    end
    load(8'h20, 8'h00, 8'h00, 8'h03);
    codes(12'h5aa, 12'h5aa);
    axi_rd(4'h4, 32'h20, ddbl_pkg::RESP_OKAY);
    cpu.mcycle(4'h1, 8'h30);
    cpu.mcycle(4'h3, 8'h0f);
    cpu.mcycle(4'h2, 8'hf0);
    for (int c = 9; c < 16; c++) cpu.mcycle(c[3:0], 8'h00);
    cpu.mcycle(4'h4, 8'h03);
    cpu.mcycle(4'h0, 8'h00);
    codes(12'hf00, 12'hf00);
    axi_wr(4'h0, 32'h1, ddbl_pkg::RESP_OKAY);
    load(8'h30, 8'h81, 8'h00, 8'h02);
    codes(12'h7ef, 12'hf00);
    axi_rd(4'h8, 32'h7ef, ddbl_pkg::RESP_OKAY);
    axi_wr(4'h0, 32'h0, ddbl_pkg::RESP_OKAY);
    axi_wr(4'h4, 32'h1, ddbl_pkg::RESP_SLVERR);
    axi_rd(4'h2, 32'h0, ddbl_pkg::RESP_SLVERR);
    axi_rd(4'h4, 32'h130, ddbl_pkg::RESP_OKAY);
    // Two's complement links: bus 7ff is positive full scale, code 000.
    input_code_links <= ddbl_pkg::CODE_TWOS;
    load(8'h30, 8'h7f, 8'hf0, 8'h02);
    codes(12'h000, 12'hf00);
    input_code_links <= ddbl_pkg::CODE_STRAIGHT;
    cpu.clear();
    cpu.mcycle(4'h0, 8'h00);
    codes(12'hfff, 12'hfff);
    chk("ch1_convert_start count", 32'h7, starts1);
    chk("ch2_convert_start count", 32'h5, starts2);
    print_verdict();
  end
  // Cuts a hang short.
  initial begin
    repeat (8000) @(posedge ref_clk);
    num_errors++;
    print_verdict();
  end
endmodule : ddbl_loader_tb_top
`default_nettype wire

// ==== tb/ddbl_props.sv ====
// Checker for latch load timing and register bus handshakes of the loader.
`default_nettype none
module ddbl_props (
  input wire logic        ref_clk,
  input wire logic        nrst,
  input wire logic        address_timing_pulse,
  input wire logic [11:0] ch1_converter_code,
  input wire logic [11:0] ch2_converter_code,
  input wire logic        ch1_convert_start,
  input wire logic        ch2_convert_start,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  // Cycles since the address pulse was last high, saturating at 15.
  logic [3:0] since_tpa_q;
  // Counts up from each address pulse so a late latch load is caught.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      since_tpa_q <= 4'hf;
    end else if (address_timing_pulse) begin
      since_tpa_q <= 4'h0;
    end else if (since_tpa_q != 4'hf) begin
      since_tpa_q <= since_tpa_q + 4'h1;
    end
  end
  property p_start1_pulse; ch1_convert_start |=> !ch1_convert_start; endproperty
  a_start1_pulse: assert property (p_start1_pulse) else $error("ch1 start too long");
  property p_start2_pulse; ch2_convert_start |=> !ch2_convert_start; endproperty
  a_start2_pulse: assert property (p_start2_pulse) else $error("ch2 start too long");
  property p_code1_cause; $changed(ch1_converter_code) |-> $past(ch1_convert_start); endproperty
  a_code1_cause: assert property (p_code1_cause) else $error("ch1 code moved alone");
  property p_code2_cause; $changed(ch2_converter_code) |-> $past(ch2_convert_start); endproperty
  a_code2_cause: assert property (p_code2_cause) else $error("ch2 code moved alone");
  property p_start_tpa; (ch1_convert_start || ch2_convert_start) |-> since_tpa_q <= 4'h6;
  endproperty
  a_start_tpa: assert property (p_start_tpa) else $error("load without address pulse");
  property p_write_answer;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:3] s_axi_bvalid;
  endproperty
  a_write_answer: assert property (p_write_answer) else $error("write response missing");
  property p_bvalid_drop; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
  a_bvalid_drop: assert property (p_bvalid_drop) else $error("write response repeated");
  property p_read_answer;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
  endproperty
  a_read_answer: assert property (p_read_answer) else $error("read response missing");
  property p_rvalid_drop; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
  a_rvalid_drop: assert property (p_rvalid_drop) else $error("read response repeated");
  c_both_start: cover property (ch1_convert_start && ch2_convert_start);
  c_write: cover property (s_axi_bvalid && s_axi_bready);
  c_read: cover property (s_axi_rvalid && s_axi_rready);
endmodule : ddbl_props
bind ddbl_loader ddbl_props u_props (.*);
`default_nettype wire
